// >>> rtl/cgt_consts.vh
/*
 Constants for the cascaded 32-bit gated timer: register byte offsets,
 control and flag bit positions, reset values and prescaler terminal counts.
 Assumes inclusion by bare name from the timer and prescaler sources.
*/
`ifndef CGT_CONSTS_VH
`define CGT_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define CGT_OFS_LOW_COUNT   8'h00
`define CGT_OFS_HIGH_COUNT  8'h04
`define CGT_OFS_HOLD        8'h08
`define CGT_OFS_PERIOD_LOW  8'h0C
`define CGT_OFS_PERIOD_HIGH 8'h10
`define CGT_OFS_LOW_CTRL    8'h14
`define CGT_OFS_HIGH_CTRL   8'h18
`define CGT_OFS_IRQ_FLAG    8'h1C
`define CGT_OFS_IRQ_ENABLE  8'h20

// ****************************************
// Field positions
// ****************************************
`define CGT_BIT_TIMER_ON    15
`define CGT_BIT_GATE_SEL    6
`define CGT_BIT_PSC_HI      5
`define CGT_BIT_PSC_LO      4
`define CGT_BIT_CLK_SRC     1
`define CGT_BIT_MATCH_FLAG  7
`define CGT_BIT_MATCH_EN    7

// ****************************************
// Reset values
// ****************************************
`define CGT_RST_COUNT       16'h0000
`define CGT_RST_PERIOD      16'hFFFF
`define CGT_RST_CTRL        16'h0000

// ****************************************
// Prescaler terminal counts for 1, 8, 64, 256
// ****************************************
`define CGT_PSC_TC_1        8'h00
`define CGT_PSC_TC_8        8'h07
`define CGT_PSC_TC_64       8'h3F
`define CGT_PSC_TC_256      8'hFF

// AXI responses
`define CGT_RESP_OKAY       2'b00
`define CGT_RESP_SLVERR     2'b10

`endif

// >>> rtl/cgt_prescaler.v
/*
 Input prescaler for the 32-bit timer: divides incoming ticks by 1, 8, 64
 or 256. Assumes tick_in is synchronous to aclk, each high cycle counting as one tick, and that
 the caller only raises clr while the prescaler clock is running.
*/
`timescale 1ns/1ps
`include "cgt_consts.vh"

module cgt_prescaler (
	// Clock and reset
	input  wire       aclk,
	input  wire       aresetn,
	// Control
	input  wire       clr,
	input  wire [1:0] prescale_select,
	// Ticks
	input  wire       tick_in,
	output wire       tick_out
);

	reg  [7:0] psc_cnt_q;
	reg  [7:0] psc_cnt_d;
	reg  [7:0] term_cnt;

	// Terminal count per divide ratio
	always @* begin
		case (prescale_select)
			2'b00:   term_cnt = `CGT_PSC_TC_1;
			2'b01:   term_cnt = `CGT_PSC_TC_8;
			2'b10:   term_cnt = `CGT_PSC_TC_64;
			default: term_cnt = `CGT_PSC_TC_256;
		endcase
	end

	assign tick_out = tick_in && !clr && (psc_cnt_q >= term_cnt);

	// Next count; a clear wins over a tick so a rewrite restarts cleanly
	always @* begin
		psc_cnt_d = psc_cnt_q;
		if (clr) begin
			psc_cnt_d = 8'h00;
		end else if (tick_in) begin
			psc_cnt_d = tick_out ? 8'h00 : psc_cnt_q + 8'h01;
		end
	end

	// Counter register, cleared by device reset
	always @(posedge aclk) begin
		if (!aresetn) begin
			psc_cnt_q <= 8'h00;
		end else begin
			psc_cnt_q <= psc_cnt_d;
		end
	end

endmodule // cgt_prescaler

// >>> rtl/cgt_timer.v
/*
 Cascaded 32-bit gated timer with AXI4-Lite register access, prescaler,
 gated accumulation, period match, converter trigger and interrupt request.
 Assumes aclk is the instruction-cycle clock and all pins are synchronous
 to it except the gate pin, which is synchronised here.
*/
// The register offsets and the AXI4-Lite register port were decided locally.
// Summary of operation
// - Gated mode counts instruction cycles only while gate pin is high.
// - Gated mode needs gate select bit 6 of low-half control.
// - Gate select bit of high-half control is ignored.
// - Gated mode works only with timer on and internal clock selected.
// - Gate falling edge stops counting and keeps the count.
// - 32-bit count equal to period emits converter trigger.
// - Prescale field bits 5:4 divides by 1, 8, 64 or 256.
// - Input clock is instruction cycle or external clock by source select.
// - Only the low-half prescaler setting is used.
// - Writing either count register clears the prescaler.
// - Clearing timer-on bit 15 of either control clears prescaler.
// - Device reset clears the prescaler.
// - Prescaler is not cleared while timer is off.
// - Writing control registers leaves counts unchanged.
// - No counting during sleep.
// - Match or gate falling edge sets flag bit 7.
// - Interrupt request only while enable bit 7 is set.
// - Count runs to period, returns to zero, continues.
// - Low half is least significant word, high half most.
// - Low count read latches high word; holding then low write loads it.
`timescale 1ns/1ps
`include "cgt_consts.vh"

module cgt_timer (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [7:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	// AXI4-Lite write data
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	output reg  [1:0]  s_axi_bresp,
	// AXI4-Lite read address
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	input  wire [7:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	// AXI4-Lite read data
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	// Device pins
	input  wire        gate_input_pin,
	input  wire        ext_clock_pin,
	input  wire        sleep_mode,
	// Event outputs
	output reg         adc_trigger,
	output reg         irq
);

	// ****************************************
	// Register state
	// ****************************************
	reg  [15:0] low_count_q;
	reg  [15:0] high_count_q;
	reg  [15:0] hold_q;
	reg  [15:0] period_low_q;
	reg  [15:0] period_high_q;
	reg  [15:0] low_ctrl_q;
	reg  [15:0] high_ctrl_q;
	reg         match_flag_q;
	reg         match_en_q;

	// Bus holding state
	reg         aw_held_q;
	reg         w_held_q;
	reg  [7:0]  aw_addr_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;

	// Pin sampling
	reg         gate_meta_q;
	reg         gate_sync_q;
	reg         gate_prev_q;
	reg         ext_prev_q;

	wire        do_wr;
	wire        do_rd;
	wire [15:0] wr_val;
	wire        wr_low_count;
	wire        wr_high_count;
	wire        wr_low_ctrl;
	wire        wr_high_ctrl;
	wire        wr_flag;
	wire        timer_on;
	wire        gated_mode;
	wire        gate_fall;
	wire        raw_tick;
	wire        psc_clr;
	wire        count_tick;
	wire [31:0] count32;
	wire [31:0] period32;
	wire        period_hit;
	wire        ton_low_off;
	wire        ton_high_off;
	wire        wr_map_ok;
	reg         rd_map_ok;
	reg  [15:0] rd_val;

	// Byte-lane merge of a 16-bit register with the write strobes
	function [15:0] merge16;
		input [15:0] old_v;
		input [15:0] new_v;
		input [1:0]  strb;
		begin
			merge16 = {strb[1] ? new_v[15:8] : old_v[15:8],
			           strb[0] ? new_v[7:0] : old_v[7:0]};
		end
	endfunction

	// ****************************************
	// AXI4-Lite handshakes
	// ****************************************

	// One write at a time: address and data wait for each other
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_wr         = aw_held_q && w_held_q && !s_axi_bvalid;
	assign do_rd         = s_axi_arvalid && s_axi_arready;

	// Capture address and data channels independently
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (do_wr) begin
				aw_held_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (do_wr) begin
				w_held_q <= 1'b0;
			end
		end
	end

	// Write decode
	assign wr_val        = w_data_q[15:0];
	assign wr_low_count  = do_wr && (aw_addr_q == `CGT_OFS_LOW_COUNT);
	assign wr_high_count = do_wr && (aw_addr_q == `CGT_OFS_HIGH_COUNT);
	assign wr_low_ctrl   = do_wr && (aw_addr_q == `CGT_OFS_LOW_CTRL);
	assign wr_high_ctrl  = do_wr && (aw_addr_q == `CGT_OFS_HIGH_CTRL);
	assign wr_flag       = do_wr && (aw_addr_q == `CGT_OFS_IRQ_FLAG);
	assign wr_map_ok     = (aw_addr_q <= `CGT_OFS_IRQ_ENABLE) && (aw_addr_q[1:0] == 2'b00);

	// Write response, unmapped addresses answer SLVERR
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `CGT_RESP_OKAY;
		end else if (do_wr) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_map_ok ? `CGT_RESP_OKAY : `CGT_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read mux, upper half of each word reads zero
	always @* begin
		rd_val    = 16'h0000;
		rd_map_ok = 1'b1;
		case (s_axi_araddr)
			`CGT_OFS_LOW_COUNT:   rd_val = low_count_q;
			`CGT_OFS_HIGH_COUNT:  rd_val = high_count_q;
			`CGT_OFS_HOLD:        rd_val = hold_q;
			`CGT_OFS_PERIOD_LOW:  rd_val = period_low_q;
			`CGT_OFS_PERIOD_HIGH: rd_val = period_high_q;
			`CGT_OFS_LOW_CTRL:    rd_val = low_ctrl_q;
			`CGT_OFS_HIGH_CTRL:   rd_val = high_ctrl_q;
			`CGT_OFS_IRQ_FLAG:    rd_val[`CGT_BIT_MATCH_FLAG] = match_flag_q;
			`CGT_OFS_IRQ_ENABLE:  rd_val[`CGT_BIT_MATCH_EN] = match_en_q;
			default:              rd_map_ok = 1'b0;
		endcase
	end

	// Read data register, answered one cycle after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `CGT_RESP_OKAY;
		end else if (do_rd) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {16'h0000, rd_val};
			s_axi_rresp  <= rd_map_ok ? `CGT_RESP_OKAY : `CGT_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************

	// Control, period and enable writes; none of these touch the count
	always @(posedge aclk) begin
		if (!aresetn) begin
			low_ctrl_q    <= `CGT_RST_CTRL;
			high_ctrl_q   <= `CGT_RST_CTRL;
			period_low_q  <= `CGT_RST_PERIOD;
			period_high_q <= `CGT_RST_PERIOD;
			hold_q        <= `CGT_RST_COUNT;
			match_en_q    <= 1'b0;
		end else begin
			if (wr_low_ctrl) begin
				low_ctrl_q <= merge16(low_ctrl_q, wr_val, w_strb_q[1:0]);
			end
			if (wr_high_ctrl) begin
				high_ctrl_q <= merge16(high_ctrl_q, wr_val, w_strb_q[1:0]);
			end
			if (do_wr && (aw_addr_q == `CGT_OFS_PERIOD_LOW)) begin
				period_low_q <= merge16(period_low_q, wr_val, w_strb_q[1:0]);
			end
			if (do_wr && (aw_addr_q == `CGT_OFS_PERIOD_HIGH)) begin
				period_high_q <= merge16(period_high_q, wr_val, w_strb_q[1:0]);
			end
			if (do_wr && (aw_addr_q == `CGT_OFS_IRQ_ENABLE) && w_strb_q[0]) begin
				match_en_q <= w_data_q[`CGT_BIT_MATCH_EN];
			end
			// Reading the low word freezes the high word for a coherent pair
			if (do_rd && (s_axi_araddr == `CGT_OFS_LOW_COUNT)) begin
				hold_q <= high_count_q;
			end else if (do_wr && (aw_addr_q == `CGT_OFS_HOLD)) begin
				hold_q <= merge16(hold_q, wr_val, w_strb_q[1:0]);
			end
		end
	end

	// ****************************************
	// Clock selection and gating
	// ****************************************

	// Gate pin through two flops; only the second and its one-cycle delayed copy are looked at
	always @(posedge aclk) begin
		if (!aresetn) begin
			gate_meta_q <= 1'b0;
			gate_sync_q <= 1'b0;
			gate_prev_q <= 1'b0;
			ext_prev_q  <= 1'b0;
		end else begin
			gate_meta_q <= gate_input_pin;
			gate_sync_q <= gate_meta_q;
			gate_prev_q <= gate_sync_q;
			ext_prev_q  <= ext_clock_pin;
		end
	end

	// Only low-half control steers the 32-bit timer
	assign timer_on   = low_ctrl_q[`CGT_BIT_TIMER_ON];
	assign gated_mode = low_ctrl_q[`CGT_BIT_GATE_SEL] && timer_on
	                    && !low_ctrl_q[`CGT_BIT_CLK_SRC];
	assign gate_fall  = gated_mode && gate_prev_q && !gate_sync_q;

	// Instruction cycle, gated cycle or external rising edge
	assign raw_tick = timer_on && !sleep_mode &&
	                  (low_ctrl_q[`CGT_BIT_CLK_SRC] ? (ext_clock_pin && !ext_prev_q)
	                  : (!low_ctrl_q[`CGT_BIT_GATE_SEL] || gate_sync_q));

	// ****************************************
	// Prescaler clearing
	// ****************************************

	// A timer-on bit going from one to zero by a control write
	assign ton_low_off  = wr_low_ctrl && w_strb_q[1] && low_ctrl_q[`CGT_BIT_TIMER_ON]
	                      && !wr_val[`CGT_BIT_TIMER_ON];
	assign ton_high_off = wr_high_ctrl && w_strb_q[1] && high_ctrl_q[`CGT_BIT_TIMER_ON]
	                      && !wr_val[`CGT_BIT_TIMER_ON];

	// Clear only while the prescaler clock runs, i.e. timer on
	assign psc_clr = timer_on && (wr_low_count || wr_high_count
	                 || ton_low_off || ton_high_off);

	// Low-half prescale field alone sets the ratio
	cgt_prescaler u_prescaler (
		.aclk            (aclk),
		.aresetn         (aresetn),
		.clr             (psc_clr),
		.prescale_select (low_ctrl_q[`CGT_BIT_PSC_HI:`CGT_BIT_PSC_LO]),
		.tick_in         (raw_tick),
		.tick_out        (count_tick)
	);

	// ****************************************
	// 32-bit counter
	// ****************************************

	// Low half is the least significant word
	assign count32    = {high_count_q, low_count_q};
	assign period32   = {period_high_q, period_low_q};
	assign period_hit = count_tick && (count32 == period32);

	// Count up to period then wrap to zero; software writes win
	always @(posedge aclk) begin
		if (!aresetn) begin
			low_count_q  <= `CGT_RST_COUNT;
			high_count_q <= `CGT_RST_COUNT;
		end else if (wr_low_count) begin
			low_count_q  <= merge16(low_count_q, wr_val, w_strb_q[1:0]);
			high_count_q <= hold_q;
		end else if (wr_high_count) begin
			high_count_q <= merge16(high_count_q, wr_val, w_strb_q[1:0]);
		end else if (period_hit) begin
			low_count_q  <= `CGT_RST_COUNT;
			high_count_q <= `CGT_RST_COUNT;
		end else if (count_tick) begin
			{high_count_q, low_count_q} <= count32 + 32'h0000_0001;
		end
	end

	// ****************************************
	// Events and interrupt
	// ****************************************

	// Flag set wins over a software clear in the same cycle
	always @(posedge aclk) begin
		if (!aresetn) begin
			match_flag_q <= 1'b0;
			adc_trigger  <= 1'b0;
			irq          <= 1'b0;
		end else begin
			if (period_hit || gate_fall) begin
				match_flag_q <= 1'b1;
			end else if (wr_flag && w_strb_q[0]) begin
				match_flag_q <= w_data_q[`CGT_BIT_MATCH_FLAG];
			end
			adc_trigger <= period_hit;
			irq         <= (match_flag_q || period_hit || gate_fall) && match_en_q;
		end
	end

endmodule // cgt_timer

// >>> tb/cgt_testbench.sv
/*
 Self-checking bench for cgt_timer: register table, period, prescale,
 gate, sleep, external clock and reset. Assumes the monitor file is compiled.
*/
`timescale 1ns/1ps
module testbench;
	typedef struct packed {
		logic        w;
		logic [7:0]  a;
		logic [15:0] d;
		logic [15:0] e;
		logic [1:0]  r;
	} cgt_row_t;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        gate, extc, sleep;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rq;
	logic [1:0]  rr;
	wire         awready, wready, bvalid, arready, rvalid, trig, irq;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	int          num_errors, n_compared, dv[4];
	cgt_row_t    rows[10];

	cgt_timer u_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .gate_input_pin(gate),
		.ext_clock_pin(extc), .sleep_mode(sleep), .adc_trigger(trig), .irq(irq));

	// 50 MHz clock
	always #10 aclk = ~aclk;

	// ********************
	// Tasks
	// ********************
	task results;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task hang;
		$display("ERROR t=%0t wait ran out: %h %h", $time, 1'h0, 1'h1);
		num_errors++;
		results();
	endtask
	task chk_reg(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// Four-state arguments so an unknown count cannot slip through as zero
	task chk_cnt(input logic [31:0] g, input logic [31:0] e);
		chk_reg(g, e);
	endtask
	// One bus access; read data or response land in rq and rr
	task automatic axi(input logic w, input logic [7:0] a, input logic [15:0] d);
		int   k;
		logic fin;
		@(posedge aclk);
		awaddr <= a;
		araddr <= a;
		wdata <= {16'h0000, d};
		{awvalid, wvalid, bready} <= {3{w}};
		{arvalid, rready} <= {2{!w}};
		k = 0;
		fin = 0;
		while (!fin && k < 50) begin
			@(posedge aclk);
			k++;
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
			if (arvalid && arready) arvalid <= 1'h0;
			if ((bready && bvalid) || (rready && rvalid)) begin
				rq = rdata;
				rr = w ? bresp : rresp;
				bready <= 1'h0;
				rready <= 1'h0;
				fin = 1;
			end
		end
		if (!fin) hang();
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		axi(1'h0, a, 16'h0000);
		chk_reg(rq, {16'h0000, e});
	endtask
	task automatic wtrig(output int n);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (trig !== 1'h1 && n < 9000);
		if (n >= 9000) hang();
	endtask
	// Spacing between two triggers, in cycles
	task automatic meas(input logic [15:0] lc, input logic [15:0] hc, input int e);
		int n;
		axi(1'h1, 8'h18, hc);
		axi(1'h1, 8'h14, lc);
		wtrig(n);
		wtrig(n);
		chk_cnt(n, e);
	endtask
	// Rising edges on the external clock pin, four cycles high and four low
	task automatic pulses(input int n);
		repeat (n) begin
			extc <= 1'h1;
			repeat (4) @(posedge aclk);
			extc <= 1'h0;
			repeat (4) @(posedge aclk);
		end
	endtask

	// ********************
	// Main sequence
	// ********************
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
		{gate, extc, sleep, awaddr, araddr, wdata} = 51'h0;
		dv = '{1, 8, 64, 256};
		rows = '{
			{1'h0, 8'h00, 16'h0000, 16'h0000, 2'h0}, {1'h0, 8'h0C, 16'h0000, 16'hFFFF, 2'h0},
			{1'h0, 8'h10, 16'h0000, 16'hFFFF, 2'h0}, {1'h0, 8'h14, 16'h0000, 16'h0000, 2'h0},
			{1'h0, 8'h1C, 16'h0000, 16'h0000, 2'h0}, {1'h1, 8'h0C, 16'h0009, 16'h0009, 2'h0},
			{1'h1, 8'h10, 16'h0000, 16'h0000, 2'h0}, {1'h1, 8'h20, 16'h0080, 16'h0080, 2'h0},
			{1'h1, 8'h24, 16'h1234, 16'h0000, 2'h2}, {1'h0, 8'h02, 16'h0000, 16'h0000, 2'h2}};
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		foreach (rows[i]) begin
			if (rows[i].w) begin
				axi(1'h1, rows[i].a, rows[i].d);
				chk_reg({30'h0, rr}, {30'h0, rows[i].r});
			end
			rd(rows[i].a, rows[i].e);
			chk_reg({30'h0, rr}, {30'h0, rows[i].r});
		end
		$display("test regs done");
		for (int i = 0; i < 4; i++)
			meas({8'h80, 2'h0, i[1:0], 4'h0}, 16'h0000, 10 * dv[i]);
		meas(16'h8000, 16'h8070, 10);
		rd(8'h1C, 16'h0080);
		chk_reg({31'h0, irq}, 32'h1);
		axi(1'h1, 8'h14, 16'h0000);
		axi(1'h1, 8'h20, 16'h0000);
		rd(8'h1C, 16'h0080);
		chk_reg({31'h0, irq}, 32'h0);
		axi(1'h1, 8'h1C, 16'h0000);
		$display("test period done");
		axi(1'h1, 8'h08, 16'h0001);
		axi(1'h1, 8'h00, 16'h0002);
		rd(8'h04, 16'h0001);
		axi(1'h1, 8'h04, 16'h0003);
		rd(8'h00, 16'h0002);
		rd(8'h08, 16'h0003);
		axi(1'h1, 8'h14, 16'h0070);
		rd(8'h00, 16'h0002);
		$display("test words done");
		axi(1'h1, 8'h0C, 16'hFFFF);
		axi(1'h1, 8'h08, 16'h0000);
		axi(1'h1, 8'h00, 16'h0000);
		axi(1'h1, 8'h14, 16'h8040);
		repeat (20) @(posedge aclk);
		gate <= 1'h1;
		repeat (50) @(posedge aclk);
		gate <= 1'h0;
		repeat (10) @(posedge aclk);
		rd(8'h00, 16'h0032);
		rd(8'h1C, 16'h0080);
		rd(8'h00, 16'h0032);
		$display("test gate done");
		axi(1'h1, 8'h14, 16'h8000);
		sleep <= 1'h1;
		axi(1'h1, 8'h00, 16'h0005);
		repeat (20) @(posedge aclk);
		rd(8'h00, 16'h0005);
		sleep <= 1'h0;
		axi(1'h1, 8'h14, 16'h0000);
		axi(1'h1, 8'h00, 16'h0000);
		axi(1'h1, 8'h14, 16'h8002);
		pulses(5);
		rd(8'h00, 16'h0005);
		// Leave three ticks in a divide-by-8 prescaler before the reset
		axi(1'h1, 8'h14, 16'h8012);
		pulses(3);
		$display("test sources done");
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		rd(8'h0C, 16'hFFFF);
		chk_reg({31'h0, irq}, 32'h0);
		// A stale prescaler would tick on the fifth edge, a cleared one on the eighth
		axi(1'h1, 8'h14, 16'h8012);
		pulses(7);
		rd(8'h00, 16'h0000);
		pulses(1);
		rd(8'h00, 16'h0001);
		$display("test reset done");
		results();
	end
endmodule // testbench

bind cgt_timer cgt_timer_monitor u_mon (.*);

// >>> tb/cgt_timer_monitor.sv
/*
 Checker for the cascaded gated timer: bus answers and event pins.
 Assumes a bind onto cgt_timer; it sees only that module's ports.
*/
`timescale 1ns/1ps
module cgt_timer_monitor (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	// Pins
	input wire logic        sleep_mode,
	input wire logic        adc_trigger,
	input wire logic        irq
);
	// ********************
	// Helper logic
	// ********************
	logic [7:0] cnt_q;

	// Cycles since a data beat, saturating so it never wraps back to a small value
	always @(posedge aclk) begin
		if (!aresetn || (s_axi_wvalid && s_axi_wready))
			cnt_q <= 8'h00;
		else if (cnt_q != 8'hFF)
			cnt_q <= cnt_q + 8'h01;
	end

	// ********************
	// Assertions
	// ********************
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// The trigger flop delays the last tick by one cycle, well inside the quiet run
	sequence asleep;
		sleep_mode [*6];
	endsequence

	wr_answer_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
		else $error("write not answered");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during response");
	rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	trig_pulse_a: assert property (adc_trigger |=> !adc_trigger)
		else $error("trigger longer than one cycle");
	sleep_still_a: assert property (asleep |-> !adc_trigger)
		else $error("trigger while asleep");
	irq_hold_a: assert property ($fell(irq) |-> cnt_q <= 8'h04)
		else $error("request dropped without a write");
endmodule // cgt_timer_monitor
